// >>> hw/sac_conv_ctrl.v
// Purpose: converter control with AHB-Lite register slave
// Assumes: pins synchronous to mclk; alt and async clocks are enables
// Notes: one-wait-free slave, every answer OKAY in the data phase
// Function
// - full scale gives all ones, floor zero
// - 10-bit across high/low; 8-bit rounded low
// - transfer completes, sets done, maybe interrupt
// - async select wins, else bus/alt select
// - dedicated clock only while converting, also stop
// - divide source by 1, 2, 4, 8
// - one channel at a time from field
// - mode field picks 10 or 8 bits
// - software write starts unless channel all ones or the trigger select bit is written set
// - hardware trigger starts conversion or series
// - continuous restarts after each transfer until abort
// - half-read 10-bit result blocks new transfer
// - blocked transfer starts another conversion unless an abort comes in the same cycle
// - abort on writes, reset, stop without async
// - abort keeps results; reset clears them
// - abort enters idle low-power state immediately, except a status write that also starts
// - 8-bit short: 18 clocks plus 3 bus; logic takes 14 (3 sample + 11 bit)
// - 8-bit long: 38 clocks plus 3 bus; logic takes 34 (23 sample + 11 bit)
// - 10-bit short: 21 clocks plus 3 bus; logic takes 14 (3 sample + 11 bit)
// - 10-bit long: 41 clocks plus 3 bus; logic takes 34 (23 sample + 11 bit)
// - done flag sets regardless of interrupt enable
// - single mode idles after completion
`include "sac_consts.vh"
module sac_conv_ctrl (
  input wire mclk,
  input wire reset_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire alt_tick,
  input wire async_tick,
  input wire hw_trigger,
  input wire stop_mode,
  input wire cmp_high,
  input wire cmp_at_high_ref,
  input wire cmp_at_low_ref,
  output reg [4:0] channel_select,
  output wire [10:0] dac_code,
  output wire sample_enable,
  output wire analog_enable,
  output wire low_power_config,
  output wire async_clk_enable,
  output wire conversion_irq
);
  // status_control_reg fields
  reg [4:0] channel_select_field; // selected input
  reg continuous_enable; // continuous series
  reg done_irq_enable; // done interrupt enable
  reg conversion_done_flag; // result ready
  reg hw_trig_select; // hardware trigger mode
  // clock_config_reg fields
  reg bus_clock_select; // bus vs alternate source
  reg [1:0] clock_divide_field; // divide ratio
  reg long_sample_select; // long sample window
  reg mode_10bit; // 1 = 10-bit results
  reg async_clock_select; // dedicated clock source
  reg low_power_cfg; // slower dedicated clock
  // results
  reg rail_high; // input at or over the high rail, held
  reg rail_low; // input at or under the low rail, held
  reg [7:0] result_low_reg; // low byte or 8-bit result
  reg [1:0] res_high; // stored upper bits
  reg half_read; // high read, low not yet
  // bus capture
  reg dp_write; // write data phase pending
  reg dp_read; // read data phase pending
  reg [7:0] dp_addr; // captured byte address
  reg series_on; // continuous series armed
  reg trig_d; // trigger edge history
  // datapath wires
  wire [10:0] raw;
  wire core_busy;
  wire core_done;
  wire conv_tick;
  wire addr_ok;
  wire sc_write;
  wire ck_write;
  wire rd_high;
  wire rd_low;
  wire stop_abort;
  wire abort;
  wire sw_start;
  wire hw_start;
  wire blocked;
  wire transfer;
  wire restart;
  wire start;
  reg [9:0] rounded; // final code
  reg [10:0] rsum; // rounding sum

  // single-cycle slave, no errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel & hready & htrans[1];

  // address phase capture; only word writes are decoded, reads of any size
  always @(posedge mclk) begin
    if (!reset_n) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_write <= addr_ok & hwrite & (hsize == 3'h2);
      dp_read <= addr_ok & ~hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  assign sc_write = dp_write & (dp_addr == `SAC_STATUS_CONTROL_OFS);
  assign ck_write = dp_write & (dp_addr == `SAC_CLOCK_CONFIG_OFS);
  assign rd_high = dp_read & (dp_addr == `SAC_RESULT_HIGH_OFS);
  assign rd_low = dp_read & (dp_addr == `SAC_RESULT_LOW_OFS);

  // stop without dedicated clock kills the conversion
  assign stop_abort = stop_mode & ~async_clock_select;
  // abort sources; core drops to idle in the same cycle unless a start comes with it
  assign abort = sc_write | ck_write | stop_abort;
  // software start after write unless channel all ones
  // the trigger select being written decides, not the stale one
  assign sw_start = sc_write & ~hwdata[`SAC_HWTRIG_BIT] &
    (hwdata[`SAC_CH_MSB:`SAC_CH_LSB] != `SAC_CH_ALL_ONES);
  // hardware trigger rising edge
  assign hw_start = hw_trig_select & hw_trigger & ~trig_d & ~core_busy &
    (channel_select_field != `SAC_CH_ALL_ONES) & ~abort;
  // half-read result blocks transfer in 10-bit mode
  assign blocked = core_done & mode_10bit & half_read;
  assign transfer = core_done & ~blocked;
  // restart: blocked always, continuous after transfer
  assign restart = blocked | (transfer & continuous_enable & series_on);
  assign start = sw_start | hw_start | (restart & ~abort);

  // trigger history
  always @(posedge mclk) begin
    if (!reset_n) begin
      trig_d <= 1'b0;
    end else begin
      trig_d <= hw_trigger;
    end
  end

  // rounding of the 11-bit approximation, clamped to full scale
  always @* begin
    if (mode_10bit) begin
      rsum = {1'b0, raw[10:1]} + {10'h000, raw[0]};
    end else begin
      rsum = {3'h0, raw[10:3]} + {10'h000, raw[2]};
    end
    rounded = rsum[9:0];
    if (mode_10bit && rsum[10]) begin
      rounded = 10'h3FF;
    end
    if (!mode_10bit && rsum[8]) begin
      rounded = 10'h0FF;
    end
    // rails force all ones or zero
    if (rail_high) begin
      rounded = mode_10bit ? 10'h3FF : 10'h0FF;
    end else if (rail_low) begin
      rounded = 10'h000;
    end
  end

  // rail flags track the comparator while converting; the comparator side is not
  // defined once the converter idles, and transfer comes after
  always @(posedge mclk) begin
    if (!reset_n) begin
      rail_high <= 1'b0;
      rail_low <= 1'b0;
    end else if (core_busy) begin
      rail_high <= cmp_at_high_ref;
      rail_low <= cmp_at_low_ref;
    end
  end

  // status and control register, with done flag
  always @(posedge mclk) begin
    if (!reset_n) begin
      channel_select_field <= `SAC_CH_ALL_ONES;
      continuous_enable <= 1'b0;
      done_irq_enable <= 1'b0;
      hw_trig_select <= 1'b0;
      conversion_done_flag <= 1'b0;
      series_on <= 1'b0;
    end else begin
      if (sc_write) begin
        channel_select_field <= hwdata[`SAC_CH_MSB:`SAC_CH_LSB];
        continuous_enable <= hwdata[`SAC_CONT_BIT];
        done_irq_enable <= hwdata[`SAC_IRQEN_BIT];
        hw_trig_select <= hwdata[`SAC_HWTRIG_BIT];
        conversion_done_flag <= 1'b0;
        series_on <= sw_start;
      end else if (hw_start) begin
        series_on <= 1'b1;
      end else if (abort) begin
        series_on <= 1'b0;
      end
      // a completed transfer wins over the clear on a low read; a write clears
      if (transfer && !abort) begin
        conversion_done_flag <= 1'b1;
      end else if (rd_low && !sc_write) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  // clock configuration register; a write aborts
  always @(posedge mclk) begin
    if (!reset_n) begin
      bus_clock_select <= 1'b0;
      clock_divide_field <= 2'h0;
      long_sample_select <= 1'b0;
      mode_10bit <= 1'b0;
      async_clock_select <= 1'b0;
      low_power_cfg <= 1'b0;
    end else if (ck_write) begin
      bus_clock_select <= hwdata[`SAC_BUSSEL_BIT];
      clock_divide_field <= hwdata[`SAC_DIV_MSB:`SAC_DIV_LSB];
      long_sample_select <= hwdata[`SAC_LONG_BIT];
      mode_10bit <= hwdata[`SAC_MODE10_BIT];
      async_clock_select <= hwdata[`SAC_ASYNC_BIT];
      low_power_cfg <= hwdata[`SAC_LOWPWR_BIT];
    end
  end

  // result registers: reset clears, abort keeps
  always @(posedge mclk) begin
    if (!reset_n) begin
      res_high <= 2'h0;
      result_low_reg <= 8'h00;
      half_read <= 1'b0;
    end else begin
      if (transfer && !abort) begin
        res_high <= mode_10bit ? rounded[9:8] : 2'h0;
        result_low_reg <= rounded[7:0];
      end
      // half-read tracking for the block
      if (rd_low) begin
        half_read <= 1'b0;
      end else if (rd_high && mode_10bit) begin
        half_read <= 1'b1;
      end
    end
  end

  // read mux, registered data output
  always @(posedge mclk) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite && hready) begin
      case (haddr[7:0])
        `SAC_STATUS_CONTROL_OFS: hrdata <= {23'h000000, hw_trig_select,
          conversion_done_flag, done_irq_enable, continuous_enable,
          channel_select_field};
        `SAC_RESULT_HIGH_OFS: hrdata <= {30'h00000000, res_high};
        `SAC_RESULT_LOW_OFS: hrdata <= {24'h000000, result_low_reg};
        `SAC_CLOCK_CONFIG_OFS: hrdata <= {25'h0000000, low_power_cfg,
          async_clock_select, mode_10bit, long_sample_select,
          clock_divide_field, bus_clock_select};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // channel to the multiplexer, one at a time
  always @(posedge mclk) begin
    if (!reset_n) begin
      channel_select <= `SAC_CH_ALL_ONES;
    end else if (sc_write) begin
      // mux follows every status and control write, so an all-ones write parks it
      channel_select <= hwdata[`SAC_CH_MSB:`SAC_CH_LSB];
    end else if (start) begin
      channel_select <= channel_select_field;
    end
  end

  // single mode: core idles after done, so analog stays off
  assign analog_enable = core_busy;
  assign low_power_config = low_power_cfg;
  // interrupt follows flag and enable
  assign conversion_irq = conversion_done_flag & done_irq_enable;

  // timing: sample 3 or 23 ticks, 11 bit ticks, sync in bus clocks;
  // dedicated source startup is outside this logic
  sac_clock_div u_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(core_busy),
    .async_sel(async_clock_select),
    .bus_sel(bus_clock_select),
    .div_sel(clock_divide_field),
    .alt_tick(alt_tick),
    .async_tick(async_tick),
    .async_clk_enable(async_clk_enable),
    .conv_tick(conv_tick)
  );

  sac_sar_core u_core (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(start),
    .abort(abort & ~start),
    .tick(conv_tick),
    .long_sample(long_sample_select),
    .cmp_high(cmp_high),
    .dac_code(dac_code),
    .sampling(sample_enable),
    .busy(core_busy),
    .done(core_done),
    .raw(raw)
  );
endmodule // sac_conv_ctrl

// >>> shared/sac_consts.vh
// Purpose: constants for the converter control block
// Assumes: AHB-Lite slave, 32-bit data, word registers
// Notes: all offsets are byte addresses
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH
// register byte offsets
`define SAC_STATUS_CONTROL_OFS 8'h00
`define SAC_RESULT_HIGH_OFS 8'h04
`define SAC_RESULT_LOW_OFS 8'h08
`define SAC_CLOCK_CONFIG_OFS 8'h0C
`define SAC_ADDR_W 8
// status_control_reg fields
`define SAC_CH_LSB 0
`define SAC_CH_MSB 4
`define SAC_CONT_BIT 5
`define SAC_IRQEN_BIT 6
`define SAC_DONE_BIT 7
`define SAC_HWTRIG_BIT 8
`define SAC_CH_ALL_ONES 5'h1F
// clock_config_reg fields
`define SAC_BUSSEL_BIT 0
`define SAC_DIV_LSB 1
`define SAC_DIV_MSB 2
`define SAC_LONG_BIT 3
`define SAC_MODE10_BIT 4
`define SAC_ASYNC_BIT 5
`define SAC_LOWPWR_BIT 6
// reset values
`define SAC_SC_RESET 9'h01F
`define SAC_CK_RESET 7'h00
// sample phase lengths in converter clocks
`define SAC_SHORT_SAMPLE 4'h3
`define SAC_LONG_SAMPLE 5'h17
// result width
`define SAC_RES_W 10
`endif

// >>> hw/sac_clock_div.v
// Purpose: clock source select and divide to the converter clock enable
// Assumes: all sources arrive as enable pulses of mclk
// Notes: divide counter restarts whenever run falls
module sac_clock_div (
  input wire mclk,
  input wire reset_n,
  input wire run,
  input wire async_sel,
  input wire bus_sel,
  input wire [1:0] div_sel,
  input wire alt_tick,
  input wire async_tick,
  output wire async_clk_enable,
  output reg conv_tick
);
  reg [2:0] div_cnt; // counts source pulses
  reg src_tick; // selected source pulse
  reg [2:0] div_max; // terminal count

  // dedicated clock only while converting with it chosen
  assign async_clk_enable = run & async_sel;

  // source mux
  always @* begin
    if (async_sel) begin
      src_tick = async_tick;
    end else if (bus_sel) begin
      src_tick = 1'b1;
    end else begin
      src_tick = alt_tick;
    end
  end

  // divide by 1, 2, 4 or 8
  always @* begin
    case (div_sel)
      2'h0: div_max = 3'h0;
      2'h1: div_max = 3'h1;
      2'h2: div_max = 3'h3;
      default: div_max = 3'h7;
    endcase
  end

  // divider counter; idle clears it so clocks stop in low power
  always @(posedge mclk) begin
    if (!reset_n || !run) begin
      div_cnt <= 3'h0;
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= 1'b0;
      if (src_tick) begin
        if (div_cnt >= div_max) begin
          div_cnt <= 3'h0;
          conv_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 3'h1;
        end
      end
    end
  end
endmodule // sac_clock_div

// >>> hw/sac_sar_core.v
// Purpose: sample phase and bit-by-bit successive approximation
// Assumes: comparator answers within one converter clock
// Notes: resolves 11 bits so the result can be rounded
module sac_sar_core (
  input wire mclk,
  input wire reset_n,
  input wire start,
  input wire abort,
  input wire tick,
  input wire long_sample,
  input wire cmp_high,
  output reg [10:0] dac_code,
  output reg sampling,
  output reg busy,
  output reg done,
  output reg [10:0] raw
);
  reg [4:0] samp_cnt; // sample clocks left
  reg [3:0] bit_idx; // bit under trial
  reg [10:0] trial_mask; // one-hot trial bit

  // sample then resolve msb first, one bit per tick
  always @(posedge mclk) begin
    if (!reset_n || abort) begin
      busy <= 1'b0;
      sampling <= 1'b0;
      done <= 1'b0;
      samp_cnt <= 5'h00;
      bit_idx <= 4'h0;
      dac_code <= 11'h000;
      raw <= 11'h000;
    end else begin
      done <= 1'b0;
      if (start) begin
        // start also restarts a running conversion
        busy <= 1'b1;
        sampling <= 1'b1;
        samp_cnt <= long_sample ? `SAC_LONG_SAMPLE
                                : {1'b0, `SAC_SHORT_SAMPLE};
        bit_idx <= 4'hA;
        dac_code <= 11'h400;
      end else if (busy && tick) begin
        if (sampling) begin
          if (samp_cnt == 5'h01) begin
            sampling <= 1'b0;
          end
          samp_cnt <= samp_cnt - 5'h01;
        end else begin
          // keep trial bit only when input stands above it
          if (!cmp_high) begin
            dac_code <= dac_code & ~trial_mask;
          end
          if (bit_idx == 4'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
            raw <= cmp_high ? dac_code : (dac_code & ~trial_mask);
          end else begin
            bit_idx <= bit_idx - 4'h1;
            dac_code <= (cmp_high ? dac_code : (dac_code & ~trial_mask))
                        | (trial_mask >> 1);
          end
        end
      end
    end
  end

  // current trial bit
  always @* begin
    trial_mask = 11'h001 << bit_idx;
  end
endmodule // sac_sar_core

// >>> test/sac_conv_ctrl_sva.sv
// Purpose: port checks of the converter control block
// Assumes: one clock, sync reset, upper haddr bits kept zero
// Notes: attached by the bind below the module
module sac_chk (
  input wire mclk,
  input wire reset_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire stop_mode,
  input wire [4:0] channel_select,
  input wire [10:0] dac_code,
  input wire sample_enable,
  input wire analog_enable,
  input wire async_clk_enable,
  input wire conversion_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // last-cycle copies, so the trial walk is seen step by step
  reg [10:0] dac_q;
  reg busy_q;
  reg samp_q;
  reg [4:0] wch_q;
  always @(posedge mclk) begin
    dac_q <= dac_code;
    busy_q <= analog_enable;
    samp_q <= sample_enable;
    wch_q <= hwdata[4:0];
  end
  // lowest set bit is the bit now on trial
  function automatic [10:0] low1(input [10:0] x);
    low1 = x & (~x + 11'h1);
  endfunction
  wire wr_ap = hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
  sequence s_sc_wr;
    wr_ap && haddr == 32'h0 ##1 1'b1;
  endsequence
  sequence s_start;
    s_sc_wr ##0 (hwdata[4:0] != 5'h1F && !hwdata[8]);
  endsequence
  property p_start;
    s_start |=> analog_enable;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_chan;
    s_sc_wr |=> channel_select == wch_q;
  endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  property p_idle;
    s_sc_wr ##0 hwdata[4:0] == 5'h1F |=> !analog_enable;
  endproperty
  a_idle: assert property (p_idle) else $error("no idle");
  property p_ck;
    wr_ap && haddr == 32'hC |-> ##2 !analog_enable;
  endproperty
  a_ck: assert property (p_ck) else $error("no ck abort");
  property p_stop;
    analog_enable && stop_mode && !async_clk_enable |=> !analog_enable;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop abort");
  property p_async;
    async_clk_enable |-> analog_enable;
  endproperty
  a_async: assert property (p_async) else $error("clock on idle");
  property p_irq;
    $rose(conversion_irq) |-> $past(analog_enable, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("stray irq");
  property p_sar;
    analog_enable && busy_q && !sample_enable && !samp_q &&
      dac_code != dac_q && !dac_q[0] |-> low1(dac_code) < low1(dac_q);
  endproperty
  a_sar: assert property (p_sar) else $error("bad trial");
endmodule // sac_chk
bind sac_conv_ctrl sac_chk u_chk (.mclk, .reset_n, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .stop_mode, .channel_select,
  .dac_code, .sample_enable, .analog_enable, .async_clk_enable,
  .conversion_irq);

// >>> test/sac_analog_model.sv
// Purpose: input mux and comparator beside the converter control
// Assumes: each level sits half a code above its value, so no ties
// Notes: outside a conversion the outputs toggle, never hold
module sac_analog_model (
  input wire mclk,
  input wire [4:0] channel_select,
  input wire [10:0] dac_code,
  input wire sample_enable,
  input wire analog_enable,
  input logic [11:0] chan_level [32],
  output wire cmp_high,
  output wire cmp_at_high_ref,
  output wire cmp_at_low_ref
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] held = 12'h0;
  logic tog = 1'b0;
  // tracking while sampling, then hold; one channel only
  wire [11:0] lv = sample_enable ? chan_level[channel_select] : held;
  always @(posedge mclk) begin
    tog <= ~tog;
    held <= lv;
  end
  // bit 11 means at or over the high rail; zero is the low rail
  assign cmp_high = analog_enable ? lv[10:0] >= dac_code : tog;
  assign cmp_at_high_ref = analog_enable ? lv[11] : tog;
  assign cmp_at_low_ref = analog_enable ? lv == 12'h0 : ~tog;
endmodule // sac_analog_model

// >>> test/tb_sac_conv_ctrl.sv
// Purpose: self-checking bench of the converter control block
// Assumes: bus source ticks each mclk; results read as words
// Notes: reads queue their expectation, a monitor compares
module tb_sac_conv_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, reset_n = 0, hsel = 0, hwrite = 0, rd_dph = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic alt_tick = 0, async_tick = 0, hw_trigger = 0, stop_mode = 0;
  logic alt_on = 1, asy_on = 0, m10, lng, ien;
  logic [11:0] levels [32];
  logic [11:0] lv, lb;
  logic [4:0] ch;
  logic [31:0] exp_q [$];
  wire [31:0] hrdata;
  wire [10:0] dac_code;
  wire [4:0] channel_select;
  wire hreadyout, hresp, cmp_high, cmp_at_high_ref, cmp_at_low_ref;
  wire sample_enable, analog_enable, low_power_config, async_clk_enable;
  wire conversion_irq;
  int err_total = 0, checks = 0, cyc = 0, n, k, dv, d, lim;
  realtime t0;
  sac_conv_ctrl dut (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .alt_tick, .async_tick, .hw_trigger, .stop_mode, .cmp_high,
    .cmp_at_high_ref, .cmp_at_low_ref, .channel_select, .dac_code,
    .sample_enable, .analog_enable, .low_power_config, .async_clk_enable,
    .conversion_irq);
  sac_analog_model u_ana (.mclk, .channel_select, .dac_code,
    .sample_enable, .analog_enable, .chan_level(levels), .cmp_high,
    .cmp_at_high_ref, .cmp_at_low_ref);
  always #2.5 mclk = ~mclk;
  // irregular source enables; a run past the ceiling is a hang
  always @(posedge mclk) begin
    alt_tick <= alt_on && $urandom % 2;
    async_tick <= asy_on && $urandom % 2;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total = err_total + 1;
      end_of_test();
    end
  end
  // read data is taken at the edge that ends its data phase
  always @(posedge mclk) begin
    if (rd_dph && hreadyout) chk(hrdata, exp_q.pop_front());
    rd_dph <= hsel && hreadyout && htrans[1] && !hwrite;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, dat, exp);
    @(posedge mclk);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= dat;
    if (!wr) exp_q.push_back(exp);
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [31:0] a, dat);
    ahb(1'b1, a, dat, 32'h0);
  endtask
  task automatic rd(input logic [31:0] a, exp);
    ahb(1'b0, a, 32'h0, exp);
  endtask
  task automatic wait_irq;
    #1;
    n = 0;
    while (conversion_irq !== 1'b1 && n < 600) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(conversion_irq, 1'b1);
  endtask
  // rounded and saturated result word, high or low
  function automatic [31:0] res(input [11:0] v, input md, input hi);
    logic [11:0] r;
    logic [11:0] top;
    top = md ? 12'h3FF : 12'hFF;
    r = md ? (v[10:0] + 12'h1) >> 1 : (v[10:0] + 12'h4) >> 3;
    if (v[11] || r > top) r = top;
    res = hi ? {30'h0, md ? r[9:8] : 2'h0} : {24'h0, r[7:0]};
  endfunction
  task automatic end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    k = $urandom(32'h65C8);
    foreach (levels[i]) levels[i] = 12'h0;
    repeat (5) @(posedge mclk);
    reset_n <= 1;
    rd(32'h0, 32'h1F);
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    wr(32'h10, 32'hFF);
    rd(32'h10, 32'h0);
    // every mode and sample length; random, full and zero levels
    for (k = 0; k < 12; k++) begin
      m10 = k[0];
      lng = k[1];
      ien = k[2] ^ k[0];
      dv = $urandom % 4;
      d = 1 << dv;
      ch = $urandom % 31;
      lv = k < 4 ? 12'h1 + $urandom % 12'h7FF : k < 8 ? 12'hFFF : 12'h0;
      levels[ch] = lv;
      lim = (m10 ? 21 : 18) + (lng ? 20 : 0);
      wr(32'hC, {27'h0, m10, lng, dv[1:0], 1'b1});
      wr(32'h0, {25'h0, ien, 1'b0, ch});
      #1 chk(analog_enable, 1'b1);
      n = 0;
      while (analog_enable === 1'b1 && n < 400) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk(n >= 10 * d && n <= lim * d + 3, 1'b1);
      // the flag sets one edge after the converter drops busy
      @(posedge mclk);
      #1 chk(conversion_irq, ien);
      // results read only once the conversion is over
      rd(32'h0, {24'h0, 1'b1, ien, 1'b0, ch});
      rd(32'h4, res(lv, m10, 1'b1));
      rd(32'h8, res(lv, m10, 1'b0));
    end
    // continuous series, later period, then abort to idle
    lv = 12'h1 + $urandom % 12'h7FF;
    levels[3] = lv;
    wr(32'hC, 32'h11);
    wr(32'h0, 32'h63);
    wait_irq;
    t0 = $realtime;
    rd(32'h8, res(lv, 1'b1, 1'b0));
    wait_irq;
    chk($realtime - t0 <= 19 * 5.0, 1'b1);
    wr(32'h0, 32'h1F);
    #1 chk(analog_enable, 1'b0);
    rd(32'h8, res(lv, 1'b1, 1'b0));
    // high read alone blocks the next transfer
    lv = 12'h1 + $urandom % 12'h3FF;
    lb = lv + 12'h400;
    levels[5] = lv;
    wr(32'h0, 32'h45);
    wait_irq;
    rd(32'h4, res(lv, 1'b1, 1'b1));
    levels[5] = lb;
    wr(32'h0, 32'h45);
    repeat (20) @(posedge mclk);
    #1 chk(conversion_irq, 1'b0);
    chk(analog_enable, 1'b1);
    rd(32'h8, res(lv, 1'b1, 1'b0));
    wait_irq;
    rd(32'h4, res(lb, 1'b1, 1'b1));
    rd(32'h8, res(lb, 1'b1, 1'b0));
    // hardware trigger mode waits for the trigger edge
    levels[2] = lv;
    wr(32'h0, 32'h142);
    repeat (20) @(posedge mclk);
    #1 chk(analog_enable, 1'b0);
    @(posedge mclk);
    hw_trigger <= 1;
    wait_irq;
    @(posedge mclk);
    hw_trigger <= 0;
    rd(32'h8, res(lv, 1'b1, 1'b0));
    // stop aborts the bus clock source, not the dedicated one
    wr(32'h0, 32'h42);
    @(posedge mclk);
    stop_mode <= 1;
    repeat (2) @(posedge mclk);
    #1 chk(analog_enable, 1'b0);
    asy_on <= 1;
    alt_on <= 0;
    wr(32'hC, 32'h31);
    wr(32'h0, 32'h42);
    #1 chk(async_clk_enable, 1'b1);
    wait_irq;
    chk(async_clk_enable, 1'b0);
    rd(32'h8, res(lv, 1'b1, 1'b0));
    @(posedge mclk);
    stop_mode <= 0;
    // alternate source selected but silent: nothing completes
    wr(32'hC, 32'h10);
    wr(32'h0, 32'h42);
    repeat (60) @(posedge mclk);
    #1 chk(conversion_irq, 1'b0);
    alt_on <= 1;
    wait_irq;
    rd(32'h8, res(lv, 1'b1, 1'b0));
    end_of_test();
  end
endmodule // tb_sac_conv_ctrl
